// *** cell_fabric.sv ***
// Cluster group of programmable logic cells with carry and cascade chains.
// Assumes an APB master on mclk; pins are asynchronous and are resynced.
// How it works
// RULE_01 - Each cell has a four-input lookup table for any function.
// RULE_02 - The cell register acts as D, T, JK or SR flip-flop.
// RULE_03 - Register clock and clear come from global, pin or logic sources.
// RULE_04 - For combinational use the register is bypassed to the outputs.
// RULE_05 - Two outputs each pick table result or register independently.
// RULE_06 - Carry and cascade pass directly between neighbour cells.
// RULE_07 - Incoming carry feeds the table and the next carry stage.
// RULE_08 - An n-bit adder uses n+1 cells; the last exports the carry.
// RULE_09 - Adder sums may leave unregistered or accumulate in the register.
// RULE_10 - Cascade combines neighbours by AND; OR through De Morgan inversion.
// RULE_11 - Each added cascade cell widens the function by four inputs.
// RULE_12 - Chains link cells 1 to 10 and run across the cluster group.
// RULE_13 - Long chains skip to the next cluster of the same parity.
// RULE_14 - Adder sum is XOR of three inputs; carry is their majority.
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module cell_fabric
(
    input wire logic mclk,
    input wire logic rst,
    input cell_pkg::apbreq_type apbReq,
    output cell_pkg::apbrsp_type apbRsp,
    input wire logic [3:0] pinIn,
    output logic [cell_pkg::TOTAL-1:0] fabricOutA,
    output logic [cell_pkg::TOTAL-1:0] fabricOutB,
    output logic [cell_pkg::CLUSTERS-1:0] chainExitQ
);
    import cell_pkg::*;

    // ------------------------------------------------------------
    // Storage and wires
    // ------------------------------------------------------------
    cellcfg_type cfgQ [TOTAL];
    logic [3:0] dataQ [TOTAL];
    logic [5:0] selQ;
    logic [3:0] globalQ;
    logic [CLUSTERS-1:0] chainInQ;
    logic [2:0] pinSync [4];
    logic [3:0] pinLevel;
    logic [TOTAL-1:0] logicQ;
    logic [TOTAL-1:0] carryOut;
    logic [TOTAL-1:0] cascOut;
    logic [TOTAL-1:0] carryIn;
    logic [TOTAL-1:0] cascIn;
    logic [TOTAL-1:0] outA;
    logic [TOTAL-1:0] outB;
    logic [TOTAL-1:0] tick;
    logic [TOTAL-1:0] clr;
    logic [TOTAL-1:0] prevClk;
    logic [TOTAL-1:0] nowClk;
    logic [TOTAL-1:0] nowClr;
    logic [CLUSTERS-1:0] exitD;
    logic access;
    logic wrEn;
    logic mapped;
    logic [31:0] rdData;
    logic [5:0] selIdx;

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    assign access = apbReq.psel && apbReq.penable;
    assign wrEn = access && apbReq.pwrite && mapped;
    assign selIdx = (selQ < 6'(TOTAL)) ? selQ : 6'h00;

    // Decode and read mux; unknown offsets answer with an error.
    always_comb
    begin
        mapped = 1'b1;
        rdData = ERR_DATA;
        unique case (apbReq.paddr[11:0])
            OFF_SELECT: rdData = {26'h0, selQ};
            OFF_CONFIG: rdData = {5'h0, cfgQ[selIdx]};
            OFF_INPUTS: rdData = {28'h0, dataQ[selIdx]};
            OFF_STATUS: rdData = {28'h0, outB[selIdx], outA[selIdx],
                carryOut[selIdx], logicQ[selIdx]};
            OFF_CHAIN: rdData = {28'h0, chainExitQ};
            OFF_GLOBAL: rdData = {28'h0, globalQ};
            default: mapped = 1'b0;
        endcase
    end

    // Zero wait states: the answer is ready in the access phase.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            apbRsp <= '0;
        end
        else
        begin
            apbRsp.pready <= apbReq.psel && !apbReq.penable;
            apbRsp.pslverr <= apbReq.psel && !apbReq.penable && !mapped;
            apbRsp.prdata <= rdData;
        end
    end

    // Writes take effect in the access cycle while pready is high.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            selQ <= 6'h00;
            globalQ <= 4'h0;
            chainInQ <= '0;
        end
        else if (wrEn && apbRsp.pready)
        begin
            if (apbReq.paddr[11:0] == OFF_SELECT)
            begin
                selQ <= apbReq.pwdata[5:0];
            end
            if (apbReq.paddr[11:0] == OFF_GLOBAL)
            begin
                globalQ <= apbReq.pwdata[3:0];
            end
            if (apbReq.paddr[11:0] == OFF_CHAIN)
            begin
                chainInQ <= apbReq.pwdata[CLUSTERS+3:4];
            end
        end
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Three stages; a change counts once stages two and three agree.
    genvar p;
    generate
        for (p = 0; p < 4; p++)
        begin : g_pin
            always_ff @(posedge mclk)
            begin
                if (rst)
                begin
                    pinSync[p] <= 3'h0;
                    pinLevel[p] <= 1'b0;
                end
                else
                begin
                    pinSync[p] <= {pinSync[p][1:0], pinIn[p]};
                    if (pinSync[p][1] == pinSync[p][2])
                    begin
                        pinLevel[p] <= pinSync[p][2];
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Cells and chain routing
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < TOTAL; i++)
        begin : g_cell
            localparam int CL = i / CELLS;
            localparam int POS = i % CELLS;
            localparam int PREV = CL - 2;
            localparam int BELOW = (i + TOTAL - 1) % TOTAL;

            // Configuration and input words written through the window.
            always_ff @(posedge mclk)
            begin
                if (rst)
                begin
                    cfgQ[i] <= cellcfg_type'(CONFIG_RESET[26:0]);
                    dataQ[i] <= 4'h0;
                end
                else if (wrEn && apbRsp.pready && selQ == 6'(i))
                begin
                    if (apbReq.paddr[11:0] == OFF_CONFIG)
                    begin
                        cfgQ[i] <= cellcfg_type'(apbReq.pwdata[26:0]);
                    end
                    if (apbReq.paddr[11:0] == OFF_INPUTS)
                    begin
                        dataQ[i] <= apbReq.pwdata[3:0];
                    end
                end
            end

            // First cell of a cluster takes the chain from two clusters
            // back, so even and odd clusters form separate chains.
            if (POS == 0 && PREV >= 0)
            begin : g_skip
                assign carryIn[i] = carryOut[PREV*CELLS+CELLS-1]; // RULE_13
                assign cascIn[i] = cascOut[PREV*CELLS+CELLS-1]; // RULE_13
            end
            else if (POS == 0)
            begin : g_head
                assign carryIn[i] = chainInQ[CL];
                assign cascIn[i] = 1'b1;
            end
            else
            begin : g_link
                assign carryIn[i] = carryOut[i-1]; // RULE_06 RULE_12
                assign cascIn[i] = cascOut[i-1]; // RULE_12
            end

            // Clock and clear sources; a logic source is the cell below.
            always_comb
            begin
                unique case (cfgQ[i].clkSel)
                    SRC_GLOBAL: nowClk[i] = globalQ[0];
                    SRC_PIN: nowClk[i] = pinLevel[0];
                    SRC_LOGIC: nowClk[i] = (i == 0) ? 1'b0 : logicQ[BELOW];
                    SRC_NONE: nowClk[i] = 1'b0;
                endcase
                unique case (cfgQ[i].clrSel)
                    SRC_GLOBAL: nowClr[i] = globalQ[1];
                    SRC_PIN: nowClr[i] = pinLevel[1];
                    SRC_LOGIC: nowClr[i] = (i == 0) ? 1'b0 : logicQ[BELOW];
                    SRC_NONE: nowClr[i] = 1'b0;
                endcase
            end // RULE_03

            // Rising edge of the chosen clock source steps the register.
            always_ff @(posedge mclk)
            begin
                if (rst)
                begin
                    prevClk[i] <= 1'b0;
                end
                else
                begin
                    prevClk[i] <= nowClk[i];
                end
            end
            assign tick[i] = nowClk[i] && !prevClk[i]; // RULE_03
            assign clr[i] = nowClr[i];

            logic_cell u_cell
            (
                .mclk(mclk),
                .rst(rst),
                .cfg(cfgQ[i]),
                .dataIn(dataQ[i] ^ {4{cfgQ[i].invert}}), // RULE_10
                .carryIn(carryIn[i]),
                .cascadeIn(cascIn[i]),
                .tickClk(tick[i]),
                .clearReq(clr[i]),
                .carryOut(carryOut[i]),
                .cascadeOut(cascOut[i]),
                .outA(outA[i]),
                .outB(outB[i]),
                .regOut(logicQ[i])
            );

            // Outputs are registered; invert restores OR after De Morgan on output A only.
            always_ff @(posedge mclk)
            begin
                if (rst)
                begin
                    fabricOutA[i] <= 1'b0;
                    fabricOutB[i] <= 1'b0;
                end
                else
                begin
                    fabricOutA[i] <= outA[i] ^ cfgQ[i].invert; // RULE_10
                    fabricOutB[i] <= outB[i];
                end
            end
        end
    endgenerate

    // The extra last cell of an adder puts its carry on general routing;
    // here the cluster's final carry is captured for the next user.
    generate
        for (i = 0; i < CLUSTERS; i++)
        begin : g_exit
            assign exitD[i] = carryOut[i*CELLS+CELLS-1]; // RULE_08
        end
    endgenerate

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            chainExitQ <= '0;
        end
        else
        begin
            chainExitQ <= exitD; // RULE_08
        end
    end

endmodule : cell_fabric

// *** cell_pkg.sv ***
// Package for the programmable logic cell cluster and its chains.
// Assumes a single mclk domain and an APB master on the register side.
package cell_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int CELLS = 10;
    localparam int CLUSTERS = 4;
    localparam int TOTAL = CELLS * CLUSTERS;
    localparam int CELL_IDX_W = 6;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] OFF_SELECT = 12'h000;
    localparam logic [11:0] OFF_CONFIG = 12'h004;
    localparam logic [11:0] OFF_INPUTS = 12'h008;
    localparam logic [11:0] OFF_STATUS = 12'h00C;
    localparam logic [11:0] OFF_CHAIN = 12'h010;
    localparam logic [11:0] OFF_GLOBAL = 12'h014;

    // ------------------------------------------------------------
    // Config word field positions
    // ------------------------------------------------------------
    localparam int TABLE_LSB = 0;
    localparam int FFMODE_LSB = 16;
    localparam int CLKSEL_LSB = 18;
    localparam int CLRSEL_LSB = 20;
    localparam int OUTA_BIT = 22;
    localparam int OUTB_BIT = 23;
    localparam int ARITH_BIT = 24;
    localparam int CASC_BIT = 25;
    localparam int INVERT_BIT = 26;

    localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
    localparam logic [31:0] ERR_DATA = 32'h0000_0000;

    typedef enum logic [1:0] {FF_D, FF_T, FF_JK, FF_SR} ffmode_type;
    typedef enum logic [1:0] {SRC_GLOBAL, SRC_PIN, SRC_LOGIC, SRC_NONE}
        ctlsrc_type;

    typedef struct packed {
        logic invert;
        logic cascEn;
        logic arith;
        logic outBReg;
        logic outAReg;
        ctlsrc_type clrSel;
        ctlsrc_type clkSel;
        ffmode_type ffMode;
        logic [15:0] lookupTable;
    } cellcfg_type;

    typedef struct packed {
        logic [31:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } apbreq_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apbrsp_type;

endpackage : cell_pkg

// *** logic_cell.sv ***
// One programmable logic cell: lookup table, chains and storage element.
// Assumes its clock-enable strobe is a one-cycle pulse on mclk.
`timescale 1ns/1ps
module logic_cell
(
    input wire logic mclk,
    input wire logic rst,
    input cell_pkg::cellcfg_type cfg,
    input wire logic [3:0] dataIn,
    input wire logic carryIn,
    input wire logic cascadeIn,
    input wire logic tickClk,
    input wire logic clearReq,
    output logic carryOut,
    output logic cascadeOut,
    output logic outA,
    output logic outB,
    output logic regOut
);
    import cell_pkg::*;

    logic [3:0] sel;
    logic tableOut;
    logic funcOut;
    logic stateQ;
    logic stateD;

    // ------------------------------------------------------------
    // Combinational path
    // ------------------------------------------------------------

    // In arithmetic mode the carry replaces input 2 (sel[2]) of the table.
    always_comb
    begin
        sel = dataIn;
        if (cfg.arith)
        begin
            sel[2] = carryIn; // RULE_07
        end
        tableOut = cfg.lookupTable[sel]; // RULE_01
        if (cfg.arith)
        begin
            // Sum is the XOR of both operands and the carry.
            funcOut = dataIn[0] ^ dataIn[1] ^ carryIn; // RULE_14
        end
        else if (cfg.cascEn)
        begin
            funcOut = tableOut & cascadeIn; // RULE_10
        end
        else
        begin
            funcOut = tableOut;
        end
    end

    // Carry is a majority vote; it goes straight to the neighbour.
    assign carryOut = (dataIn[0] & dataIn[1]) | (dataIn[0] & carryIn)
        | (dataIn[1] & carryIn); // RULE_06 RULE_14
    assign cascadeOut = funcOut; // RULE_06 RULE_11

    // ------------------------------------------------------------
    // Storage element
    // ------------------------------------------------------------

    // The function result is D/T/J/S, data 3 is K/R for two-input modes.
    always_comb
    begin
        unique case (cfg.ffMode)
            FF_D: stateD = funcOut;
            FF_T: stateD = stateQ ^ funcOut;
            FF_JK: stateD = (funcOut & ~stateQ) | (~dataIn[3] & stateQ);
            FF_SR: stateD = funcOut | (stateQ & ~dataIn[3]);
        endcase
    end // RULE_02

    // Clear wins over a clock tick, so a cell cannot load while its clear is held.
    always_ff @(posedge mclk)
    begin
        if (rst || clearReq)
        begin
            stateQ <= 1'b0; // RULE_03
        end
        else if (tickClk)
        begin
            stateQ <= stateD; // RULE_09
        end
    end

    // Each output picks register or table result independently.
    assign outA = cfg.outAReg ? stateQ : funcOut; // RULE_04 RULE_05
    assign outB = cfg.outBReg ? stateQ : funcOut; // RULE_05
    assign regOut = stateQ;

endmodule : logic_cell

// *** cell_chains_props.sv ***
// Checker for the cell fabric: bus answers, reset and output stability.
// Assumes it is bound to cell_fabric and sees only that module's ports.
`timescale 1ns/1ps
module cell_chains_props
(
    input wire logic mclk,
    input wire logic rst,
    input cell_pkg::apbreq_type apbReq,
    input cell_pkg::apbrsp_type apbRsp,
    input wire logic [3:0] pinIn,
    input wire logic [cell_pkg::TOTAL-1:0] fabricOutA,
    input wire logic [cell_pkg::TOTAL-1:0] fabricOutB,
    input wire logic [cell_pkg::CLUSTERS-1:0] chainExitQ
);
    import cell_pkg::*;
    logic mapped;
    logic [3:0] quietQ;
    // --------
    // Helpers
    // --------
    // The six aligned words from SELECT to GLOBAL are decoded.
    assign mapped = apbReq.paddr[11:0] <= OFF_GLOBAL &&
        apbReq.paddr[1:0] == 2'h0;
    // Counts cycles without a bus write or pin change; outputs have no
    // other cause to move, so a long quiet spell must leave them alone.
    always_ff @(posedge mclk)
    begin
        if (rst || (apbReq.psel && apbReq.pwrite) || pinIn != $past(pinIn))
            quietQ <= 4'h0;
        else if (quietQ != 4'hF)
            quietQ <= quietQ + 4'h1;
    end
    // --------
    // Properties
    // --------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    sequence s_setup;
        apbReq.psel && !apbReq.penable;
    endsequence
    sequence s_done;
        apbReq.psel && apbReq.penable && apbRsp.pready;
    endsequence
    property p_ready_after_setup;
        s_setup |=> apbRsp.pready;
    endproperty
    a_ready_after_setup: assert property (p_ready_after_setup)
        else $error("Ready missing one cycle after setup.");
    property p_ready_in_access;
        apbRsp.pready |-> apbReq.psel && apbReq.penable;
    endproperty
    a_ready_in_access: assert property (p_ready_in_access)
        else $error("Ready outside an access phase.");
    property p_ready_one;
        apbRsp.pready |=> !apbRsp.pready;
    endproperty
    a_ready_one: assert property (p_ready_one)
        else $error("Ready held longer than one cycle.");
    property p_refuse;
        s_done ##0 !mapped |-> apbRsp.pslverr && apbRsp.prdata == ERR_DATA;
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("Unmapped offset not refused.");
    property p_accept;
        s_done ##0 mapped |-> !apbRsp.pslverr;
    endproperty
    a_accept: assert property (p_accept)
        else $error("Mapped offset refused.");
    property p_err_ready;
        apbRsp.pslverr |-> apbRsp.pready;
    endproperty
    a_err_ready: assert property (p_err_ready)
        else $error("Error flag without ready.");
    property p_reset;
        $fell(rst) |-> fabricOutA == '0 && fabricOutB == '0 &&
            chainExitQ == '0;
    endproperty
    a_reset: assert property (p_reset)
        else $error("Outputs not cleared by reset.");
    property p_quiet;
        quietQ >= 4'hA |-> $stable(fabricOutA) && $stable(fabricOutB) &&
            $stable(chainExitQ);
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("Outputs moved without a cause.");
endmodule : cell_chains_props

// *** pin_partner.sv ***
// Outside source of the clock and clear pins of the fabric.
// Assumes requests are one-cycle pulses; idle pins sit low.
`timescale 1ns/1ps
module pin_partner
(
    input wire logic mclk,
    input wire logic [3:0] pulseReq,
    input wire logic [3:0] holdLen,
    output logic [3:0] pinIn
);
    logic [3:0] maskQ = 4'h0;
    logic [3:0] cntQ = 4'h0;
    // Pins are pulled low when not driven, so idle shows a fixed level.
    assign pinIn = (cntQ != 4'h0) ? maskQ : 4'h0;
    // Each request holds its pins high for holdLen cycles; short holds
    // test a prompt source, long ones a slow source.
    always @(posedge mclk)
    begin
        if (pulseReq != 4'h0)
        begin
            maskQ <= pulseReq;
            cntQ <= holdLen;
        end
        else if (cntQ != 4'h0)
            cntQ <= cntQ - 4'h1;
    end
endmodule : pin_partner

// *** tb_programmable_logic_cell_chains.sv ***
// Self-checking bench for the logic cell fabric over its register bus.
// Assumes cell_pkg, cell_fabric, pin_partner and the checker are compiled.
`timescale 1ns/1ps
module tb_programmable_logic_cell_chains;
    import cell_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    apbreq_type apbReq = '0;
    apbrsp_type apbRsp;
    logic [3:0] pinIn;
    logic [3:0] pulseReq = 4'h0;
    logic [3:0] holdLen = 4'h4;
    logic [TOTAL-1:0] fabricOutA;
    logic [TOTAL-1:0] fabricOutB;
    logic [CLUSTERS-1:0] chainExitQ;
    logic [31:0] rdData;
    logic rdErr;
    int n_errors = 0;
    int checks = 0;
    // Free-running 125 MHz clock.
    always #4 mclk = ~mclk;
    cell_fabric dut_u (.mclk(mclk), .rst(rst), .apbReq(apbReq),
        .apbRsp(apbRsp), .pinIn(pinIn), .fabricOutA(fabricOutA),
        .fabricOutB(fabricOutB), .chainExitQ(chainExitQ));
    pin_partner pin_u (.mclk(mclk), .pulseReq(pulseReq),
        .holdLen(holdLen), .pinIn(pinIn));
    // --------
    // Bus and compare tasks
    // --------
    // One transfer; ready is sampled at the rising edge that ends the
    // access phase, and the request is released only at that edge.
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge mclk);
        apbReq <= '{{20'h0, a}, 1'b1, 1'b0, w, d};
        @(posedge mclk);
        apbReq.penable <= 1'b1;
        @(posedge mclk);
        while (apbRsp.pready !== 1'b1)
            @(posedge mclk);
        rdData = apbRsp.prdata;
        rdErr = apbRsp.pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
    endtask : apb
    task automatic chk(input logic [63:0] got, input logic [63:0] exp,
        input string what);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask : chk
    function automatic cellcfg_type mk(logic [15:0] t, ffmode_type m,
        ctlsrc_type s, logic oa, ob, ar, cs, iv);
        return '{iv, cs, ar, ob, oa, s, s, m, t};
    endfunction : mk
    task automatic cfg(input int c, input cellcfg_type v);
        apb(1'b1, OFF_SELECT, 32'(c));
        apb(1'b1, OFF_CONFIG, 32'(v));
    endtask : cfg
    task automatic ins(input int c, input logic [3:0] v);
        apb(1'b1, OFF_SELECT, 32'(c));
        apb(1'b1, OFF_INPUTS, {28'h0, v});
        repeat (3) @(posedge mclk);
    endtask : ins
    task automatic glb(input logic [1:0] v);
        apb(1'b1, OFF_GLOBAL, {30'h0, v});
        apb(1'b1, OFF_GLOBAL, 32'h0);
        repeat (3) @(posedge mclk);
    endtask : glb
    task automatic pin(input logic [3:0] m, input logic [3:0] h);
        @(posedge mclk);
        pulseReq <= m;
        holdLen <= h;
        @(posedge mclk);
        pulseReq <= 4'h0;
        repeat (24) @(posedge mclk);
    endtask : pin
    // --------
    // Scenarios
    // --------
    task automatic t_regs;
        cellcfg_type v;
        v = mk(16'h1234, FF_JK, SRC_PIN, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
        apb(1'b0, OFF_CONFIG, 32'h0);
        chk(rdData, CONFIG_RESET, "config reset");
        chk({fabricOutA, chainExitQ}, '0, "outputs reset");
        apb(1'b1, 12'h018, 32'h0000_00FF);
        chk(rdErr, 1'b1, "unmapped write");
        apb(1'b0, 12'h018, 32'h0);
        chk({rdErr, rdData}, {1'b1, ERR_DATA}, "unmapped read");
        cfg(4, v);
        apb(1'b0, OFF_CONFIG, 32'h0);
        chk({rdErr, rdData}, {1'b0, 32'(v)}, "config readback");
        $display("test regs done");
    endtask : t_regs
    task automatic t_lut;
        logic [15:0] tbl;
        tbl = 16'hA5C3;
        cfg(3, mk(tbl, FF_D, SRC_NONE, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
        for (int v = 0; v < 16; v++)
        begin
            ins(3, 4'(v));
            chk({fabricOutA[3], fabricOutB[3]}, {2{tbl[v]}}, "lut");
        end
        $display("test lut done");
    endtask : t_lut
    task automatic t_modes;
        cellcfg_type v;
        // Cell 6 toggles on each rising edge of cell 5's register.
        v = mk(16'hFFFF, FF_T, SRC_LOGIC, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        v.clrSel = SRC_NONE;
        cfg(6, v);
        for (int m = 0; m < 4; m++)
        begin
            cfg(5, mk(16'hFFFF, ffmode_type'(m), SRC_GLOBAL, 1'b0, 1'b1,
                1'b0, 1'b0, 1'b0));
            ins(5, 4'h0);
            glb(2'h2);
            chk({fabricOutA[5], fabricOutB[5]}, 2'b10, "clear");
            glb(2'h1);
            chk(fabricOutB[5], 1'b1, "tick");
            chk(fabricOutB[6], m % 2 == 0, "logic clock");
            glb(2'h1);
            chk(fabricOutB[5], m != 1, "second tick");
        end
        $display("test modes done");
    endtask : t_modes
    task automatic t_pin;
        cfg(7, mk(16'hFFFF, FF_D, SRC_PIN, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0));
        pin(4'h1, 4'h4);
        chk(fabricOutB[7], 1'b1, "pin clock");
        pin(4'h2, 4'hC);
        chk(fabricOutB[7], 1'b0, "pin clear");
        $display("test pin done");
    endtask : t_pin
    task automatic t_adder;
        for (int c = 0; c < 3; c++)
            cfg(c, mk(16'h9696, FF_D, SRC_NONE, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0));
        for (int k = 0; k < 32; k++)
        begin
            apb(1'b1, OFF_CHAIN, {27'h0, k[4], 4'h0});
            ins(0, {2'b00, k[2], k[0]});
            ins(1, {2'b00, k[3], k[1]});
            chk(fabricOutA[2:0], k[1:0] + k[3:2] + k[4], "adder");
        end
        // Cluster 2 takes cluster 0's last carry, which also leaves as exit.
        cfg(20, mk(16'h0000, FF_D, SRC_NONE, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0));
        for (int b = 0; b < 2; b++)
        begin
            ins(9, {2'b00, b[0], b[0]});
            chk({fabricOutA[20], chainExitQ[0]}, {2{b[0]}},
                "skip");
        end
        $display("test adder done");
    endtask : t_adder
    task automatic t_cascade;
        logic [9:0] cs [6] = '{10'h1FF, 10'h0FE, 10'h1FC, 10'h200, 10'h209,
            10'h241};
        foreach (cs[i])
        begin
            for (int c = 10; c < 12; c++)
                cfg(c, mk(16'h8000, FF_D, SRC_NONE, 1'b0, 1'b0, 1'b0, 1'b1,
                    cs[i][9]));
            ins(10, cs[i][8:5]);
            ins(11, cs[i][4:1]);
            chk(fabricOutA[11], cs[i][0], "cascade");
        end
        $display("test cascade done");
    endtask : t_cascade
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : report_and_stop
    // Main sequence: reset for 20 cycles, then each scenario in turn.
    initial
    begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        t_regs();
        t_lut();
        t_modes();
        t_pin();
        t_adder();
        t_cascade();
        report_and_stop();
    end
    // Watchdog: the run needs about 1300 cycles, so 200 us is ample.
    initial
    begin
        #200000;
        n_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        report_and_stop();
    end
endmodule : tb_programmable_logic_cell_chains
bind cell_fabric cell_chains_props props_u (.mclk(mclk), .rst(rst),
    .apbReq(apbReq), .apbRsp(apbRsp), .pinIn(pinIn),
    .fabricOutA(fabricOutA), .fabricOutB(fabricOutB),
    .chainExitQ(chainExitQ));
